// ---- core/pms_pkg.sv ----
// Package of constants, types and helpers for the time-protocol master selector.
// Operation
// - Rank priority1, class, accuracy, variance, priority2, identifier.
// - Smaller field value marks the better clock.
// - First differing field decides; later fields ignored.
// - Priority1 and priority2 are separate 8-bit fields.
// - Unique identifier breaks full ties, one winner.
// - Local dataset: priority1 128, class 248, accuracy FE.
// - Local dataset: variance FFFF, priority2 122.
// - One-step adjusts sync and delay-request in transit.
// - Two-step carries timestamps in follow-up, delay-response.
// - Best-clock port is slave, all others master.
// - Intercept time-protocol messages, pass other traffic.
// - Only end-to-end two-step operation is supported.
package pms_pkg;

   // ==========================================================
   // Sizes and local dataset
   localparam int NPORT = 4;
   localparam int PW = 2;
   localparam logic [7:0] LOC_PRIO1 = 8'h80;
   localparam logic [7:0] LOC_CLASS = 8'hF8;
   localparam logic [7:0] LOC_ACC = 8'hFE;
   localparam logic [15:0] LOC_VAR = 16'hFFFF;
   localparam logic [7:0] LOC_PRIO2 = 8'h7A;

   // ==========================================================
   // Message types, roles and reset values
   localparam logic [3:0] MT_SYNC = 4'h0;
   localparam logic [3:0] MT_DREQ = 4'h1;
   localparam logic [3:0] MT_FUP = 4'h8;
   localparam logic [3:0] MT_DRESP = 4'h9;
   localparam logic [3:0] MT_ANN = 4'hB;
   localparam logic ROLE_MASTER = 1'b0;
   localparam logic ROLE_SLAVE = 1'b1;
   localparam logic [63:0] TIME_ZERO = 64'h0;
   localparam logic [NPORT-1:0] ROLE_RST = 4'h0;

   // ==========================================================
   // Types
   // Dataset fields in comparison order, most significant first.
   typedef struct packed {
      logic [7:0] prio1;         // Own 8-bit field.
      logic [7:0] clk_class;
      logic [7:0] accuracy;
      logic [15:0] variance;
      logic [7:0] prio2;         // Own 8-bit field.
      logic [63:0] clock_id;
   } pms_ds_t;

   // Message descriptor, used for receive, pass-through and transmit.
   typedef struct packed {
      logic is_ptp;
      logic [3:0] msg_type;
      logic two_step;
      logic [PW-1:0] port;
      logic [NPORT-1:0] dst_mask;
      logic [63:0] corr;
      logic [63:0] tstamp;
      pms_ds_t ds;
   } pms_msg_t;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_SYNC = 2'b01,
      TX_FUP = 2'b10
   } pms_txst_t;

   // ==========================================================
   // Helpers
   // One-hot port mask from a port index.
   function automatic logic [NPORT-1:0] pms_onehot(input logic [PW-1:0] idx);
      pms_onehot = 4'h1 << idx;
   endfunction : pms_onehot

   // Checks a received descriptor for a given protocol message type.
   function automatic logic pms_is(input pms_msg_t m, input logic [3:0] t);
      pms_is = m.is_ptp && (m.msg_type == t);
   endfunction : pms_is

endpackage : pms_pkg

// ---- core/pms_cmp.sv ----
// Dataset comparator: tells whether candidate a is a better clock than b.
`timescale 1ns/10ps
module pms_cmp
   import pms_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input pms_ds_t a,
   input pms_ds_t b,
   output logic a_better
);

   // ==========================================================
   // Ordering
   // The packed dataset puts fields in ranking order, so one unsigned compare
   // lets the first differing field decide, smaller winning, identifier last.
   assign a_better = (a < b);

   // ==========================================================
   // Checks
   chk_prio1_first: assert property (@(posedge core_clk) disable iff (sys_rst)
      (a.prio1 < b.prio1) |-> a_better)
      else $error("smaller priority1 did not win");
   chk_later_ignored: assert property (@(posedge core_clk) disable iff (sys_rst)
      (a.prio1 > b.prio1) |-> !a_better)
      else $error("later field overrode priority1");
   chk_prio2_smaller: assert property (@(posedge core_clk) disable iff (sys_rst)
      (a[111:72] == b[111:72]) && (a.prio2 < b.prio2) |-> a_better)
      else $error("smaller priority2 did not win");
   chk_id_tiebreak: assert property (@(posedge core_clk) disable iff (sys_rst)
      (a[111:64] == b[111:64]) && (a.clock_id != b.clock_id) |-> (a_better == (a.clock_id < b.clock_id)))
      else $error("identifier tie break not decisive");

endmodule : pms_cmp

// ---- core/pms_top.sv ----
// Master selection, port roles and two-step event handling for a time-protocol node.
`timescale 1ns/10ps
module pms_top
   import pms_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic rx_valid,
   input pms_msg_t rx_msg,
   input wire logic [63:0] local_id,
   input wire logic [63:0] local_time,
   input wire logic sync_req,
   output logic fwd_valid,
   output pms_msg_t fwd_msg,
   output logic tx_valid,
   output pms_msg_t tx_msg,
   output logic [NPORT-1:0] port_role,
   output pms_ds_t gm_ds,
   output logic gm_local,
   output logic t1_valid,
   output logic [63:0] t1_time,
   output logic unsup_pulse
);

   // ==========================================================
   // State
   logic [NPORT-1:0] ann_vld_r;
   pms_ds_t ann_ds_r [NPORT];
   logic [PW-1:0] scan_idx_r;
   pms_ds_t best_r;
   logic best_loc_r;
   logic [PW-1:0] best_port_r;
   logic [PW-1:0] gm_port_r;
   logic sync_pend_r;
   logic [63:0] sync_corr_r;
   logic req_pend_r;
   pms_txst_t st_r;
   pms_txst_t st_nxt;
   logic [63:0] txt_r;
   logic dh_vld_r;
   pms_msg_t dh_msg_r;
   pms_msg_t tx_nxt;
   logic tx_vld_nxt;

   // ==========================================================
   // Local dataset and scan selection
   pms_ds_t local_ds;
   pms_ds_t base_ds;
   pms_ds_t cand_ds;
   pms_ds_t best_nxt;
   logic cand_better;
   logic take;
   logic base_loc;
   logic [PW-1:0] base_port;
   logic scan_end;

   // The advertised local quality figures.
   assign local_ds = '{prio1: LOC_PRIO1, clk_class: LOC_CLASS, accuracy: LOC_ACC,
                       variance: LOC_VAR, prio2: LOC_PRIO2, clock_id: local_id};
   // Each scan pass starts from the local clock and visits one port per cycle.
   assign base_ds = (scan_idx_r == '0) ? local_ds : best_r;
   assign base_loc = (scan_idx_r == '0) ? 1'b1 : best_loc_r;
   assign base_port = (scan_idx_r == '0) ? '0 : best_port_r;
   assign cand_ds = ann_ds_r[scan_idx_r];
   assign take = ann_vld_r[scan_idx_r] && cand_better;
   assign best_nxt = take ? cand_ds : base_ds;
   assign scan_end = (scan_idx_r == PW'(NPORT - 1));

   pms_cmp u_cmp (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .a(cand_ds),
      .b(base_ds),
      .a_better(cand_better)
   );

   // ==========================================================
   // Receive decode
   logic rx_ptp;
   logic on_slave;
   logic sync_hit;
   logic onestep_hit;
   logic fup_hit;
   logic dreq_hit;
   logic fup_busy;

   assign rx_ptp = rx_valid && rx_msg.is_ptp;
   assign on_slave = (port_role[rx_msg.port] == ROLE_SLAVE);
   // Only two-step syncs are accepted; one-step ones are refused.
   assign sync_hit = rx_valid && pms_is(rx_msg, MT_SYNC) && on_slave && rx_msg.two_step;
   assign onestep_hit = rx_valid && pms_is(rx_msg, MT_SYNC) && on_slave && !rx_msg.two_step;
   assign fup_hit = rx_valid && pms_is(rx_msg, MT_FUP) && on_slave && sync_pend_r;
   assign dreq_hit = rx_valid && pms_is(rx_msg, MT_DREQ) && !on_slave;
   assign fup_busy = (st_r == TX_FUP);

   // ==========================================================
   // Announce storage, one dataset per port
   genvar gi;
   generate
      for (gi = 0; gi < NPORT; gi++) begin : g_ann
         // Latest announced dataset seen on this port.
         always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
               ann_vld_r[gi] <= 1'b0;
               ann_ds_r[gi] <= '0;
            end else if (rx_valid && pms_is(rx_msg, MT_ANN) && (rx_msg.port == PW'(gi))) begin
               ann_vld_r[gi] <= 1'b1;
               ann_ds_r[gi] <= rx_msg.ds;
            end
         end
      end
   endgenerate

   // ==========================================================
   // Election scan and port roles
   // At the end of each pass the winner becomes the grandmaster view.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         scan_idx_r <= '0;
         best_r <= '0;
         best_loc_r <= 1'b1;
         best_port_r <= '0;
         gm_ds <= '0;
         gm_local <= 1'b1;
         gm_port_r <= '0;
         port_role <= ROLE_RST;
      end else begin
         scan_idx_r <= scan_end ? '0 : scan_idx_r + PW'(1);
         best_r <= best_nxt;
         best_loc_r <= take ? 1'b0 : base_loc;
         best_port_r <= take ? scan_idx_r : base_port;
         if (scan_end) begin
            gm_ds <= best_nxt;
            gm_local <= take ? 1'b0 : base_loc;
            gm_port_r <= take ? scan_idx_r : base_port;
            // One slave port toward the best clock, every other port master.
            port_role <= (take || !base_loc) ? pms_onehot(take ? scan_idx_r : base_port) : ROLE_RST;
         end
      end
   end

   // ==========================================================
   // Pass-through and slave-side two-step reception
   // Non-protocol traffic goes out unchanged; protocol messages stay here.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fwd_valid <= 1'b0;
         fwd_msg <= '0;
      end else begin
         fwd_valid <= rx_valid && !rx_msg.is_ptp;
         if (rx_valid && !rx_msg.is_ptp) begin
            fwd_msg <= rx_msg;
         end
      end
   end

   // Sync correction is kept until the matching follow-up brings the origin time.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync_pend_r <= 1'b0;
         sync_corr_r <= TIME_ZERO;
         t1_valid <= 1'b0;
         t1_time <= TIME_ZERO;
         unsup_pulse <= 1'b0;
      end else begin
         t1_valid <= fup_hit;
         unsup_pulse <= onestep_hit;
         if (sync_hit) begin
            sync_pend_r <= 1'b1;
            sync_corr_r <= rx_msg.corr; // Accumulated switch residence.
         end else if (fup_hit) begin
            sync_pend_r <= 1'b0;
         end
         if (fup_hit) begin
            // Origin plus both corrections gives the corrected send time.
            t1_time <= rx_msg.tstamp + sync_corr_r + rx_msg.corr;
         end
      end
   end

   // ==========================================================
   // Master-side transmit: sync, follow-up and delay responses
   pms_msg_t dresp_msg;

   // A delay response carries the receive time and moves the request's correction.
   assign dresp_msg = '{is_ptp: 1'b1, msg_type: MT_DRESP, two_step: 1'b1, port: rx_msg.port,
                        dst_mask: pms_onehot(rx_msg.port), corr: rx_msg.corr,
                        tstamp: local_time, ds: '0};

   // Follow-up has a fixed slot; a held response goes before a new one, sync waits.
   always_comb begin
      st_nxt = st_r;
      tx_nxt = '0;
      tx_vld_nxt = 1'b0;
      if (fup_busy) begin
         tx_nxt = '{is_ptp: 1'b1, msg_type: MT_FUP, two_step: 1'b1, port: '0,
                    dst_mask: ~port_role, corr: TIME_ZERO, tstamp: txt_r, ds: '0};
         tx_vld_nxt = 1'b1;
         st_nxt = TX_IDLE;
      end else if (dh_vld_r) begin
         tx_nxt = dh_msg_r;
         tx_vld_nxt = 1'b1;
      end else if (dreq_hit) begin
         tx_nxt = dresp_msg;
         tx_vld_nxt = 1'b1;
      end else if (st_r == TX_SYNC) begin
         // Event message leaves with an empty timestamp.
         tx_nxt = '{is_ptp: 1'b1, msg_type: MT_SYNC, two_step: 1'b1, port: '0,
                    dst_mask: ~port_role, corr: TIME_ZERO, tstamp: TIME_ZERO, ds: '0};
         tx_vld_nxt = 1'b1;
         st_nxt = TX_FUP;
      end
      case (st_r)
         TX_IDLE: begin
            if (req_pend_r) begin
               st_nxt = TX_SYNC;
            end
         end
         TX_SYNC: begin
         end
         TX_FUP: begin
         end
         default: begin
            st_nxt = TX_IDLE;
         end
      endcase
   end

   // Transmit registers, request latch and one-deep response hold.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= TX_IDLE;
         req_pend_r <= 1'b0;
         txt_r <= TIME_ZERO;
         dh_vld_r <= 1'b0;
         dh_msg_r <= '0;
         tx_valid <= 1'b0;
         tx_msg <= '0;
      end else begin
         st_r <= st_nxt;
         tx_valid <= tx_vld_nxt;
         tx_msg <= tx_nxt;
         // A new request wins over the clear in the same cycle.
         req_pend_r <= sync_req || (req_pend_r && (st_r != TX_IDLE));
         if ((st_r == TX_SYNC) && (st_nxt == TX_FUP)) begin
            txt_r <= local_time;
         end
         dh_vld_r <= dreq_hit && (fup_busy || dh_vld_r);
         if (dreq_hit && (fup_busy || dh_vld_r)) begin
            dh_msg_r <= dresp_msg;
         end
      end
   end

   // ==========================================================
   // Checks
   sequence sync_out;
      tx_valid && (tx_msg.msg_type == MT_SYNC) && tx_msg.two_step && (tx_msg.tstamp == TIME_ZERO);
   endsequence
   sequence fup_out;
      tx_valid && (tx_msg.msg_type == MT_FUP);
   endsequence

   chk_fup_follows: assert property (@(posedge core_clk) disable iff (sys_rst)
      sync_out |=> fup_out ##0 (tx_msg.tstamp == $past(local_time, 2)))
      else $error("follow-up missing or wrong time");
   chk_role_local: assert property (@(posedge core_clk) disable iff (sys_rst)
      gm_local |-> (port_role == ROLE_RST))
      else $error("slave port while local clock is best");
   chk_role_slave: assert property (@(posedge core_clk) disable iff (sys_rst)
      !gm_local |-> (port_role == pms_onehot(gm_port_r)))
      else $error("slave port does not face best clock");
   chk_pass_data: assert property (@(posedge core_clk) disable iff (sys_rst)
      (rx_valid && !rx_msg.is_ptp) |=> fwd_valid && (fwd_msg == $past(rx_msg)))
      else $error("other traffic altered");
   chk_ptp_held: assert property (@(posedge core_clk) disable iff (sys_rst)
      rx_ptp |=> !fwd_valid)
      else $error("protocol message passed through");
   chk_local_qual: assert property (@(posedge core_clk) disable iff (sys_rst)
      (ann_vld_r == '0) [*5] |-> gm_local && (gm_ds.prio1 == 8'h80) && (gm_ds.clk_class == 8'hF8)
      && (gm_ds.accuracy == 8'hFE))
      else $error("local quality figures wrong");
   chk_local_prio2: assert property (@(posedge core_clk) disable iff (sys_rst)
      (ann_vld_r == '0) [*5] |-> (gm_ds.variance == 16'hFFFF) && (gm_ds.prio2 == 8'h7A))
      else $error("local variance or priority2 wrong");
   chk_onestep_drop: assert property (@(posedge core_clk) disable iff (sys_rst)
      onestep_hit |=> unsup_pulse && $stable(sync_corr_r))
      else $error("one-step sync accepted");
   chk_t1_sum: assert property (@(posedge core_clk) disable iff (sys_rst)
      fup_hit |=> t1_valid && (t1_time == $past(rx_msg.tstamp) + $past(sync_corr_r) + $past(rx_msg.corr)))
      else $error("corrected origin time wrong");
   chk_dresp_corr: assert property (@(posedge core_clk) disable iff (sys_rst)
      (dreq_hit && !fup_busy && !dh_vld_r) |=> tx_valid && (tx_msg.msg_type == MT_DRESP)
      && (tx_msg.corr == $past(rx_msg.corr)) && (tx_msg.tstamp == $past(local_time)))
      else $error("delay response wrong");
   chk_one_slave: assert property (@(posedge core_clk) disable iff (sys_rst)
      $onehot0(port_role))
      else $error("more than one slave port");
   chk_sync_mask: assert property (@(posedge core_clk) disable iff (sys_rst)
      sync_out |-> (tx_msg.dst_mask == ~$past(port_role)))
      else $error("sync not sent to every master port");

endmodule : pms_top

// ---- verif/pms_peer.sv ----
// Far-side model: networked clocks and transparent switches feeding the node.
`timescale 1ns/10ps
module pms_peer
   import pms_pkg::*;
(
   input wire logic core_clk,
   output logic rx_valid,
   output pms_msg_t rx_msg
);
   // ==========================================================
   // Message launch
   // Nothing is offered before the first message.
   initial begin
      rx_valid = 1'b0;
      rx_msg = '0;
   end

   // Offers one message for exactly one edge, then scrambles the stale bus.
   task automatic send(input pms_msg_t m);
      @(posedge core_clk);
      #1;
      rx_valid = 1'b1;
      rx_msg = m;
      @(posedge core_clk);
      #1;
      rx_valid = 1'b0;
      rx_msg = ~m;
   endtask : send

   // Passes an event message through an end-to-end switch, adding its residence time.
   task automatic relay(input pms_msg_t m, input logic [63:0] t_in, input logic [63:0] t_out);
      m.corr = m.corr + (t_out - t_in);
      send(m); // No ingress line delay is added.
   endtask : relay
endmodule : pms_peer

// ---- verif/pms_top_tb_top.sv ----
// Self-checking testbench for master election and two-step event handling.
`timescale 1ns/10ps
module pms_top_tb_top
   import pms_pkg::*;
;
   // ==========================================================
   // Signals and model state
   localparam logic [111:0] ONE = 112'h1;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic rx_valid;
   pms_msg_t rx_msg;
   logic [63:0] local_id = 64'h0;
   logic [63:0] local_time = 64'h0;
   logic sync_req = 1'b0;
   logic fwd_valid, tx_valid, gm_local, t1_valid, unsup_pulse;
   pms_msg_t fwd_msg, tx_msg, m;
   logic [NPORT-1:0] port_role;
   pms_ds_t gm_ds;
   logic [63:0] t1_time, lt1, lt2, c1, ti;
   logic [111:0] loc_v, d;
   int num_errors = 0;
   int check_count = 0;
   int cyc_cnt = 0;
   int n;
   int lo [6] = '{104, 96, 88, 72, 64, 0};
   pms_ds_t ann [NPORT];
   logic [NPORT-1:0] have = '0;

   pms_top DUT (.core_clk(core_clk), .sys_rst(sys_rst), .rx_valid(rx_valid), .rx_msg(rx_msg),
      .local_id(local_id), .local_time(local_time), .sync_req(sync_req), .fwd_valid(fwd_valid),
      .fwd_msg(fwd_msg), .tx_valid(tx_valid), .tx_msg(tx_msg), .port_role(port_role), .gm_ds(gm_ds),
      .gm_local(gm_local), .t1_valid(t1_valid), .t1_time(t1_time), .unsup_pulse(unsup_pulse));
   pms_peer peer (.core_clk(core_clk), .rx_valid(rx_valid), .rx_msg(rx_msg));

   // Clock of 25 ns.
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end

   // Local time steps after each edge; history keeps the values sampled at edges.
   always @(posedge core_clk) begin
      lt1 <= local_time;
      lt2 <= lt1;
      local_time <= #1 local_time + 64'h1;
   end

   // Cuts a hung run short.
   always @(posedge core_clk) begin
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         num_errors++;
         stop_test();
      end
   end

   // ==========================================================
   // Helpers
   task automatic check(input logic [255:0] seen, input logic [255:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask : tick

   function automatic logic [63:0] rnd64();
      return {$urandom, $urandom};
   endfunction : rnd64

   task automatic do_reset();
      sys_rst = 1'b1;
      tick(10);
      sys_rst = 1'b0;
      have = '0;
   endtask : do_reset

   task automatic announce(input int p, input pms_ds_t ds);
      m = '0;
      m.is_ptp = 1'b1;
      m.msg_type = MT_ANN;
      m.port = p[PW-1:0];
      m.corr = rnd64();
      m.ds = ds;
      peer.send(m);
      ann[p] = ds;
      have[p] = 1'b1;
   endtask : announce

   // A candidate beats another only when strictly smaller in field order.
   function automatic logic beats(input pms_ds_t a, input pms_ds_t b);
      return {a.prio1, a.clk_class, a.accuracy, a.variance, a.prio2, a.clock_id} <
         {b.prio1, b.clk_class, b.accuracy, b.variance, b.prio2, b.clock_id};
   endfunction : beats

   // Model of the election over the stored announcements.
   task automatic check_election();
      pms_ds_t best;
      int bp;
      best = loc_v;
      bp = -1;
      for (int p = 0; p < NPORT; p++) begin
         if (have[p] && beats(ann[p], best)) begin
            best = ann[p];
            bp = p;
         end
      end
      check(gm_ds, best);
      check(gm_local, bp < 0);
      check(port_role, (bp < 0) ? 4'h0 : 4'h1 << bp);
   endtask : check_election

   task automatic stop_test();
      $display("Checks %0d, errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : stop_test

   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(32'hb8cc82c9));
      local_id = ({$urandom, $urandom} >> 1) | 64'h1;
      loc_v = {8'h80, 8'hF8, 8'hFE, 16'hFFFF, 8'h7A, local_id};
      do_reset();
      tick(6);
      check(gm_ds.prio1, 8'h80);
      check(gm_ds.clk_class, 8'hF8);
      check(gm_ds.accuracy, 8'hFE);
      check(gm_ds.variance, 16'hFFFF);
      check(gm_ds.prio2, 8'h7A);
      check_election();
      // Each field decides alone; the last pass is an exact tie that keeps the local clock.
      for (int f = 0; f < 7; f++) begin
         do_reset();
         if (f < 6) begin
            announce(0, (loc_v + (ONE << lo[f])) & ~((ONE << lo[f]) - ONE));
            announce(1, (loc_v - (ONE << lo[f])) | ((ONE << lo[f]) - ONE));
         end
         announce(3, loc_v);
         tick(10);
         check_election();
      end
      // Random candidates around the local dataset.
      for (int r = 0; r < 16; r++) begin
         d = loc_v;
         for (int f = 0; f < 6; f++) begin
            d = d + (112'($urandom_range(2)) << lo[f]) - (ONE << lo[f]);
         end
         announce($urandom_range(3), d);
         tick(10);
         check_election();
      end
      // Port 2 sees a clearly better clock and becomes the only slave port.
      do_reset();
      announce(2, loc_v & ~(112'hFF << 104));
      tick(10);
      check_election();
      m = '0;
      m.msg_type = 4'($urandom);
      m.port = 2'h1;
      m.corr = rnd64();
      m.tstamp = rnd64();
      peer.send(m);
      check(fwd_valid, 1'b1);
      check(fwd_msg, m);
      // Two-step pairing on the slave port; master-port events are ignored.
      c1 = rnd64();
      ti = rnd64();
      m = '0;
      m.is_ptp = 1'b1;
      m.two_step = 1'b1;
      m.port = 2'h2;
      m.corr = c1;
      peer.relay(m, ti, 64'(ti + 64'h3E8));
      check(fwd_valid, 1'b0);
      m.port = 2'h0;
      m.corr = rnd64();
      peer.send(m);
      m.msg_type = MT_FUP;
      peer.send(m);
      check(t1_valid, 1'b0);
      m.port = 2'h2;
      m.corr = rnd64();
      m.tstamp = rnd64();
      peer.send(m);
      check(t1_valid, 1'b1);
      check(t1_time, 64'(m.tstamp + c1 + 64'h3E8 + m.corr));
      m.msg_type = MT_SYNC;
      m.two_step = 1'b0;
      peer.send(m);
      check(unsup_pulse, 1'b1);
      // Delay requests: answered on a master port, ignored on the slave port.
      m = '0;
      m.is_ptp = 1'b1;
      m.msg_type = MT_DREQ;
      m.port = 2'h1;
      m.corr = rnd64();
      peer.send(m);
      check(tx_valid, 1'b1);
      check(tx_msg.msg_type, MT_DRESP);
      check(tx_msg.corr, m.corr);
      check(tx_msg.tstamp, lt1);
      check(tx_msg.dst_mask, 4'h2);
      m.port = 2'h2;
      peer.send(m);
      check(tx_valid, 1'b0);
      // Two back-to-back sync requests give two sync and follow-up pairs.
      sync_req = 1'b1;
      tick(2);
      sync_req = 1'b0;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         while (!(tx_valid === 1'b1 && tx_msg.msg_type === MT_SYNC) && n < 20) begin
            tick(1);
            n++;
         end
         check(tx_valid, 1'b1);
         check(tx_msg.two_step, 1'b1);
         check(tx_msg.dst_mask, 4'hB);
         check(tx_msg.tstamp, 64'h0);
         tick(1);
         check(tx_valid, 1'b1);
         check(tx_msg.msg_type, MT_FUP);
         check(tx_msg.tstamp, lt2);
      end
      stop_test();
   end
endmodule : pms_top_tb_top
